// >>> rtl/pil_front_end.sv
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
// Operation
// - negative-true term: hold while high, pass low
// - positive-true term: hold while low, pass high
// - enable is OR of two polarized terms
// - held transitions appear only when enable returns
// - demux copies lower byte into upper latch
// - demux: upper group latched, lower sampled
// - sample clock captures latch outputs
// - sample-mode groups ignore the enable, except the upper group in demux
// - internal mode samples at programmed period
// - enable false freezes latched channels at current level
// - terms positive, negative or unused-false
module pil_front_end
	import pil_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// probe pins from the target
	input wire logic [15:0] probe_in,
	input wire logic section_a_enable_first,
	input wire logic section_a_enable_second,
	input wire logic ext_sample_clk,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// recorded stream
	output logic [15:0] sample_data,
	output logic sample_valid
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [18:0] pin_meta_reg;
	logic [18:0] pin_sync_reg;
	logic [15:0] probe_s;
	logic en1_s;
	logic en2_s;
	logic ext_clk_s;
	logic ext_clk_d_reg;

	// two flops on every asynchronous pin
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			ext_clk_d_reg <= 1'b0;
		end else if (clk_en) begin
			pin_meta_reg <= {ext_sample_clk, section_a_enable_second,
				section_a_enable_first, probe_in};
			pin_sync_reg <= pin_meta_reg;
			ext_clk_d_reg <= ext_clk_s;
		end
	end

	// probes and enables ride one flop chain, so a latch decision never
	// pairs an enable with a probe level from a different cycle
	assign probe_s = pin_sync_reg[15:0];
	assign en1_s = pin_sync_reg[16];
	assign en2_s = pin_sync_reg[17];
	assign ext_clk_s = pin_sync_reg[18];

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [3:0] group_mode_reg;
	logic [3:0] enable_cfg_reg;
	logic [15:0] clk_period_reg;
	logic [1:0] control_reg;
	logic [15:0] rdata_reg;
	pil_state_e state_reg;
	pil_state_e state_next;
	logic recording;
	logic cfg_locked;
	logic wr_mode;
	logic wr_enable;
	logic wr_period;
	logic wr_control;

	// the lock follows the state, so it engages one cycle after the run bit
	assign recording = (state_reg == PIL_ST_RUN);
	// reconfiguring mid-record would corrupt the trace, so lock it
	assign cfg_locked = recording;
	assign wr_mode = reg_wr && (reg_addr == PIL_OFS_GROUP_MODE) && !cfg_locked;
	assign wr_enable = reg_wr && (reg_addr == PIL_OFS_ENABLE_CFG) && !cfg_locked;
	assign wr_period = reg_wr && (reg_addr == PIL_OFS_CLK_PERIOD) && !cfg_locked;
	assign wr_control = reg_wr && (reg_addr == PIL_OFS_CONTROL);

	// a write while clk_en is low is lost, not deferred
	// register writes; run bit may always change
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			group_mode_reg <= PIL_GROUP_MODE_RST;
			enable_cfg_reg <= PIL_ENABLE_CFG_RST;
			clk_period_reg <= PIL_CLK_PERIOD_RST;
			control_reg <= PIL_CONTROL_RST;
		end else if (clk_en) begin
			if (wr_mode) begin
				group_mode_reg <= reg_wdata[3:0];
			end
			if (wr_enable) begin
				enable_cfg_reg <= reg_wdata[3:0];
			end
			if (wr_period) begin
				clk_period_reg <= reg_wdata;
			end
			if (wr_control) begin
				control_reg[PIL_CTL_RUN_POS] <= reg_wdata[PIL_CTL_RUN_POS];
				if (!cfg_locked) begin
					control_reg[PIL_CTL_INT_POS] <= reg_wdata[PIL_CTL_INT_POS];
				end
			end
		end
	end

	// recording state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PIL_ST_IDLE: begin
				if (control_reg[PIL_CTL_RUN_POS]) begin
					state_next = PIL_ST_RUN;
				end
			end
			PIL_ST_RUN: begin
				if (!control_reg[PIL_CTL_RUN_POS]) begin
					state_next = PIL_ST_IDLE;
				end
			end
			default: state_next = PIL_ST_IDLE;
		endcase
	end

	// state register; illegal codes fall back to idle via the next-state default
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= PIL_ST_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// enable expression
	// ------------------------------------------------------------
	pil_term_e term1_cfg;
	pil_term_e term2_cfg;
	logic term1;
	logic term2;
	logic section_enable;

	// term code 3 is not legal and falls through to unused below
	assign term1_cfg = pil_term_e'(enable_cfg_reg[PIL_TERM1_POS +: 2]);
	assign term2_cfg = pil_term_e'(enable_cfg_reg[PIL_TERM2_POS +: 2]);

	// each term: positive true, negative true, or unused as false
	assign term1 = (term1_cfg == PIL_TERM_POS_TRUE) ? en1_s :
		(term1_cfg == PIL_TERM_NEG_TRUE) ? !en1_s : 1'b0;
	assign term2 = (term2_cfg == PIL_TERM_POS_TRUE) ? en2_s :
		(term2_cfg == PIL_TERM_NEG_TRUE) ? !en2_s : 1'b0;
	// either term alone can open the latch
	assign section_enable = term1 || term2;

	// ------------------------------------------------------------
	// per-group latch
	// ------------------------------------------------------------
	logic [15:0] latch_reg;
	logic [15:0] latch_src;
	logic [15:0] group_out;
	pil_mode_e mode_lo;
	pil_mode_e mode_hi;
	logic demux;

	assign mode_lo = pil_mode_e'(group_mode_reg[PIL_MODE_LO_POS +: 2]);
	assign mode_hi = pil_mode_e'(group_mode_reg[PIL_MODE_HI_POS +: 2]);
	// demux on either group puts the section in demux
	assign demux = (mode_lo == PIL_MODE_DEMUX) || (mode_hi == PIL_MODE_DEMUX);
	// in demux the upper latch is fed from the lower pins
	assign latch_src = demux ? {probe_s[7:0], probe_s[7:0]} : probe_s;

	// one pass per group of eight channels
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : grp
			pil_mode_e gmode;
			logic use_latch;
			assign gmode = (g == 0) ? mode_lo : mode_hi;
			// demux: upper latched, lower plain sampled
			assign use_latch = demux ? (g == 1) : (gmode == PIL_MODE_LATCH);

			// limitation: enables are seen through the synchroniser, so
			// enable pulses shorter than one core cycle can be missed
			// level latch modelled as a hold register: transparent on
			// enable, frozen at last passed level when enable drops
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					latch_reg[g*8 +: 8] <= 8'h00;
				end else if (clk_en && section_enable) begin
					latch_reg[g*8 +: 8] <= latch_src[g*8 +: 8];
				end
			end

			// transparent path so a true enable passes current level
			assign group_out[g*8 +: 8] = !use_latch ? latch_src[g*8 +: 8] :
				section_enable ? latch_src[g*8 +: 8] :
				latch_reg[g*8 +: 8];
		end
	endgenerate

	// ------------------------------------------------------------
	// sample clock and capture
	// ------------------------------------------------------------
	logic int_tick;
	logic ext_tick;
	logic sample_tick;
	logic [15:0] sample_reg;
	logic valid_reg;

	// internal period counter, running only while recording
	pil_tick_gen u_tick (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.run(recording),
		.period_ns(clk_period_reg),
		.tick(int_tick)
	);

	// rising edge of the synchronised external clock; edges closer than
	// two core cycles apart merge in the synchroniser
	assign ext_tick = recording && ext_clk_s && !ext_clk_d_reg;
	// internal mode ignores the external clock pin entirely
	assign sample_tick = control_reg[PIL_CTL_INT_POS] ? int_tick : ext_tick;

	// valid pulses for one cycle; the data stand until the next sample
	// capture latch outputs, not raw pins
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sample_reg <= 16'h0000;
			valid_reg <= 1'b0;
		end else if (clk_en) begin
			valid_reg <= sample_tick;
			if (sample_tick) begin
				sample_reg <= group_out;
			end
		end
	end

	assign sample_data = sample_reg;
	assign sample_valid = valid_reg;

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic sel_mode;
	logic sel_cfg;
	logic sel_period;
	logic sel_control;
	logic sel_status;
	logic sel_sample;
	logic sel_latched;
	logic [15:0] status_word;
	logic [15:0] rd_mux;

	// one select line per offset; unmapped offsets leave every line low
	assign sel_mode = (reg_addr == PIL_OFS_GROUP_MODE);
	assign sel_cfg = (reg_addr == PIL_OFS_ENABLE_CFG);
	assign sel_period = (reg_addr == PIL_OFS_CLK_PERIOD);
	assign sel_control = (reg_addr == PIL_OFS_CONTROL);
	assign sel_status = (reg_addr == PIL_OFS_STATUS);
	assign sel_sample = (reg_addr == PIL_OFS_SAMPLE);
	assign sel_latched = (reg_addr == PIL_OFS_LATCHED);
	// live combined enable lets software check the enable wiring
	assign status_word = {14'h0, section_enable, recording};

	// and-or mux: selects are one-hot, so unmapped offsets read zero
	assign rd_mux = ({16{sel_mode}} & {12'h000, group_mode_reg}) |
		({16{sel_cfg}} & {12'h000, enable_cfg_reg}) |
		({16{sel_period}} & clk_period_reg) |
		({16{sel_control}} & {14'h0, control_reg}) |
		({16{sel_status}} & status_word) |
		({16{sel_sample}} & sample_reg) |
		({16{sel_latched}} & group_out);

	// registered so the data stand in the cycle after the strobe
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= 16'h0000;
		end else if (clk_en && reg_rd) begin
			rdata_reg <= rd_mux;
		end
	end

	assign reg_rdata = rdata_reg;

endmodule

// >>> rtl/pil_pkg.sv
package pil_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] PIL_OFS_GROUP_MODE = 4'h0;
	localparam logic [3:0] PIL_OFS_ENABLE_CFG = 4'h1;
	localparam logic [3:0] PIL_OFS_CLK_PERIOD = 4'h2;
	localparam logic [3:0] PIL_OFS_CONTROL = 4'h3;
	localparam logic [3:0] PIL_OFS_STATUS = 4'h4;
	localparam logic [3:0] PIL_OFS_SAMPLE = 4'h5;
	localparam logic [3:0] PIL_OFS_LATCHED = 4'h6;

	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int PIL_MODE_LO_POS = 0;
	localparam int PIL_MODE_HI_POS = 2;
	localparam int PIL_TERM1_POS = 0;
	localparam int PIL_TERM2_POS = 2;
	localparam int PIL_CTL_RUN_POS = 0;
	localparam int PIL_CTL_INT_POS = 1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0] PIL_GROUP_MODE_RST = 4'h0;
	localparam logic [3:0] PIL_ENABLE_CFG_RST = 4'ha;
	localparam logic [15:0] PIL_CLK_PERIOD_RST = 16'h0028;
	localparam logic [1:0] PIL_CONTROL_RST = 2'h2;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int PIL_CORE_PERIOD_NS = 10;
	localparam int PIL_INT_PERIOD_NS = 40;
	localparam int PIL_INT_PERIOD_CYC = PIL_INT_PERIOD_NS / PIL_CORE_PERIOD_NS;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PIL_MODE_SAMPLE = 2'h0,
		PIL_MODE_LATCH = 2'h1,
		PIL_MODE_DEMUX = 2'h2
	} pil_mode_e;

	typedef enum logic [1:0] {
		PIL_TERM_POS_TRUE = 2'h0,
		PIL_TERM_NEG_TRUE = 2'h1,
		PIL_TERM_UNUSED = 2'h2
	} pil_term_e;

	typedef enum logic [1:0] {
		PIL_ST_IDLE = 2'h0,
		PIL_ST_RUN = 2'h1
	} pil_state_e;

endpackage

// >>> rtl/pil_tick_gen.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// internal sample clock: one pulse per programmed period
// ------------------------------------------------------------
module pil_tick_gen
	import pil_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// control
	input wire logic run,
	input wire logic [15:0] period_ns,
	// result
	output logic tick
);

	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [15:0] period_cyc;
	logic wrap;

	// period in core cycles, never below one cycle
	assign period_cyc = (period_ns < 16'(PIL_CORE_PERIOD_NS)) ? 16'h0001 :
		16'(period_ns / 16'(PIL_CORE_PERIOD_NS));
	assign wrap = (count_reg >= period_cyc - 16'h0001);
	assign count_next = (!run || wrap) ? 16'h0000 : count_reg + 16'h0001;
	assign tick = run && wrap;

	// free counter while running
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= 16'h0000;
		end else if (clk_en) begin
			count_reg <= count_next;
		end
	end

endmodule

// >>> testbench/pil_front_end_assertions.sv
`timescale 1ns/1ps
module pil_chk
	import pil_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// watched ports
	input wire logic [15:0] probe_in,
	input wire logic section_a_enable_first,
	input wire logic section_a_enable_second,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] sample_data,
	input wire logic sample_valid
);
	logic [3:0] mode_reg, cfg_reg, pst_reg, est_reg, idle_reg;
	logic [15:0] per_reg, p_reg;
	logic [1:0] e_reg;
	logic int_reg, rec_reg, run_reg, en_exp;
	function automatic logic term_on(input logic [1:0] m, input logic p);
		return (m == 2'h0) ? p : ((m == 2'h1) ? !p : 1'b0);
	endfunction
	// expected combined enable, from raw pins (checked only once they settle)
	assign en_exp = term_on(cfg_reg[1:0], section_a_enable_first)
		| term_on(cfg_reg[3:2], section_a_enable_second);
	// shadow setup; writes during recording are dropped, as in the block
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_reg <= PIL_GROUP_MODE_RST;
			cfg_reg <= PIL_ENABLE_CFG_RST;
			per_reg <= PIL_CLK_PERIOD_RST;
			int_reg <= PIL_CONTROL_RST[1];
			rec_reg <= 1'b0;
			run_reg <= 1'b0;
			p_reg <= 16'h0000;
			e_reg <= 2'h0;
			pst_reg <= 4'h0;
			est_reg <= 4'h0;
			idle_reg <= 4'h0;
		end else if (clk_en) begin
			if (reg_wr && !rec_reg && reg_addr == PIL_OFS_GROUP_MODE) mode_reg <= reg_wdata[3:0];
			if (reg_wr && !rec_reg && reg_addr == PIL_OFS_ENABLE_CFG) cfg_reg <= reg_wdata[3:0];
			if (reg_wr && !rec_reg && reg_addr == PIL_OFS_CLK_PERIOD) per_reg <= reg_wdata;
			if (reg_wr && !rec_reg && reg_addr == PIL_OFS_CONTROL) int_reg <= reg_wdata[1];
			// the block locks one cycle after the run bit, when its state follows
			if (reg_wr && reg_addr == PIL_OFS_CONTROL) run_reg <= reg_wdata[0];
			rec_reg <= run_reg;
			p_reg <= probe_in;
			e_reg <= {section_a_enable_first, section_a_enable_second};
			pst_reg <= (probe_in != p_reg) ? 4'h0 : pst_reg + {3'h0, pst_reg != 4'hf};
			est_reg <= (e_reg != {section_a_enable_first, section_a_enable_second}) ? 4'h0
				: est_reg + {3'h0, est_reg != 4'hf};
			idle_reg <= rec_reg ? 4'h0 : idle_reg + {3'h0, idle_reg != 4'hf};
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_comb;
		reg_rd && reg_addr == PIL_OFS_STATUS && est_reg >= 4'h4 |=> reg_rdata[1] == $past(en_exp);
	endproperty
	a_comb: assert property (p_comb) else $error("combined enable wrong");
	property p_smp_grp;
		reg_rd && reg_addr == PIL_OFS_LATCHED && mode_reg == 4'h0 && pst_reg >= 4'h4
			|=> reg_rdata == $past(probe_in);
	endproperty
	a_smp_grp: assert property (p_smp_grp) else $error("sample group not live");
	property p_demux;
		reg_rd && reg_addr == PIL_OFS_LATCHED && mode_reg == 4'h2 && en_exp && est_reg >= 4'h4
			&& pst_reg >= 4'h4 |=> reg_rdata == {2{$past(probe_in[7:0])}};
	endproperty
	a_demux: assert property (p_demux) else $error("demux copy wrong");
	property p_smp_data;
		sample_valid && mode_reg == 4'h0 && pst_reg >= 4'h6 |-> sample_data == probe_in;
	endproperty
	a_smp_data: assert property (p_smp_data) else $error("sample data wrong");
	property p_lock;
		reg_rd && reg_addr == PIL_OFS_GROUP_MODE |=> reg_rdata == {12'h000, $past(mode_reg)};
	endproperty
	a_lock: assert property (p_lock) else $error("mode changed while recording");
	property p_cfg;
		reg_rd && reg_addr == PIL_OFS_ENABLE_CFG |=> reg_rdata == {12'h000, $past(cfg_reg)};
	endproperty
	a_cfg: assert property (p_cfg) else $error("term setup readback wrong");
	property p_space;
		sample_valid && int_reg && per_reg == 16'h0028 |=> !sample_valid [*3];
	endproperty
	a_space: assert property (p_space) else $error("samples too close");
	property p_quiet;
		idle_reg >= 4'h4 |-> !sample_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("sample while stopped");
endmodule
bind pil_front_end pil_chk u_pil_chk (.core_clk(core_clk), .reset_n(reset_n),
	.clk_en(clk_en), .probe_in(probe_in), .section_a_enable_first(section_a_enable_first),
	.section_a_enable_second(section_a_enable_second), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sample_data(sample_data), .sample_valid(sample_valid));

// >>> testbench/pil_target_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// probed target: drives clean registered levels on the pins
// ------------------------------------------------------------
module pil_target_model (
	// bench commands
	input wire logic core_clk,
	input wire logic [15:0] want_probe,
	input wire logic want_e1,
	input wire logic want_e2,
	input wire logic want_clk,
	// probe pins
	output logic [15:0] probe_in,
	output logic en1,
	output logic en2,
	output logic ext_clk
);
	// levels move only just after an edge, so the enables never glitch
	initial begin
		probe_in = 16'h0000;
		en1 = 1'b0;
		en2 = 1'b0;
		ext_clk = 1'b0;
	end
	// the sample clock stands low unless the bench asks for an edge
	always @(posedge core_clk) begin
		probe_in <= want_probe;
		en1 <= want_e1;
		en2 <= want_e2;
		ext_clk <= want_clk;
	end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench
	import pil_pkg::*;
;
	logic core_clk, reset_n, clk_en, reg_wr, reg_rd, sample_valid;
	logic en1, en2, ext_clk, want_e1, want_e2, want_clk;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, sample_data, probe_in, want_probe;
	int failures, checks_done, n;
	pil_front_end u_pil_front_end (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
		.probe_in(probe_in), .section_a_enable_first(en1), .section_a_enable_second(en2),
		.ext_sample_clk(ext_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sample_data(sample_data), .sample_valid(sample_valid));
	pil_target_model u_pil_target_model (.core_clk(core_clk), .want_probe(want_probe),
		.want_e1(want_e1), .want_e2(want_e2), .want_clk(want_clk), .probe_in(probe_in),
		.en1(en1), .en2(en2),
		.ext_clk(ext_clk));
	// ------------------------------------------------------------
	// bus and check helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand from the cycle after the strobe, so look there
	task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	// pins take two sync flops plus the model's own flop, so allow six cycles
	task automatic pins(input logic [15:0] p, input logic a, input logic b);
		@(posedge core_clk);
		want_probe <= p;
		want_e1 <= a;
		want_e2 <= b;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic wait_sv();
		n = 0;
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (sample_valid !== 1'b1 && n < 50);
	endtask
	task automatic tally_and_finish();
		$display("checks_done %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rdchk(PIL_OFS_GROUP_MODE, {12'h000, PIL_GROUP_MODE_RST});
		rdchk(PIL_OFS_ENABLE_CFG, {12'h000, PIL_ENABLE_CFG_RST});
		rdchk(PIL_OFS_CLK_PERIOD, PIL_CLK_PERIOD_RST);
		rdchk(PIL_OFS_CONTROL, {14'h0, PIL_CONTROL_RST});
	endtask
	task automatic t_latch();
		wr(PIL_OFS_GROUP_MODE, 16'h0001);
		wr(PIL_OFS_ENABLE_CFG, 16'h0008);
		pins(16'h12aa, 1'b1, 1'b0);
		rdchk(PIL_OFS_LATCHED, 16'h12aa);
		pins(16'h3455, 1'b0, 1'b0);
		rdchk(PIL_OFS_LATCHED, 16'h34aa);
		pins(16'h3455, 1'b1, 1'b0);
		rdchk(PIL_OFS_LATCHED, 16'h3455);
		wr(PIL_OFS_ENABLE_CFG, 16'h0009);
		pins(16'h0011, 1'b0, 1'b0);
		rdchk(PIL_OFS_LATCHED, 16'h0011);
		pins(16'h0022, 1'b1, 1'b0);
		rdchk(PIL_OFS_LATCHED, 16'h0011);
		wr(PIL_OFS_ENABLE_CFG, 16'h0000);
		pins(16'h0033, 1'b0, 1'b1);
		rdchk(PIL_OFS_LATCHED, 16'h0033);
		pins(16'h0044, 1'b0, 1'b0);
		rdchk(PIL_OFS_LATCHED, 16'h0033);
		wr(PIL_OFS_ENABLE_CFG, 16'h000a);
		pins(16'h0055, 1'b1, 1'b1);
		rdchk(PIL_OFS_LATCHED, 16'h0033);
		rdchk(PIL_OFS_STATUS, 16'h0000);
		wr(PIL_OFS_ENABLE_CFG, 16'h0004);
		pins(16'h0066, 1'b0, 1'b0);
		rdchk(PIL_OFS_LATCHED, 16'h0066);
	endtask
	task automatic t_demux();
		wr(PIL_OFS_GROUP_MODE, 16'h0002);
		wr(PIL_OFS_ENABLE_CFG, 16'h0008);
		pins(16'hff5a, 1'b1, 1'b0);
		rdchk(PIL_OFS_LATCHED, 16'h5a5a);
		pins(16'hffa5, 1'b0, 1'b0);
		rdchk(PIL_OFS_LATCHED, 16'h5aa5);
	endtask
	task automatic t_stream();
		wr(PIL_OFS_GROUP_MODE, 16'h0000);
		// term 1 positive but low: the enable is false, sample groups ignore it
		wr(PIL_OFS_ENABLE_CFG, 16'h0008);
		pins(16'hc3c3, 1'b0, 1'b0);
		wr(PIL_OFS_CONTROL, 16'h0003);
		wait_sv();
		chk(sample_data, 16'hc3c3);
		wait_sv();
		chk(16'(n), 16'h0004);
		pins(16'h3c3c, 1'b1, 1'b0);
		wait_sv();
		chk(sample_data, 16'h3c3c);
		wr(PIL_OFS_GROUP_MODE, 16'h0001);
		rdchk(PIL_OFS_GROUP_MODE, 16'h0000);
		rdchk(PIL_OFS_STATUS, 16'h0003);
		wr(PIL_OFS_CONTROL, 16'h0002);
		repeat (4) @(posedge core_clk);
		wait_sv();
		chk(16'(n), 16'h0032);
	endtask
	// external clock: model flop, two sync flops and the capture make four edges
	task automatic t_ext();
		wr(PIL_OFS_CONTROL, 16'h0001);
		pins(16'h0f0f, 1'b0, 1'b0);
		@(posedge core_clk);
		want_clk <= 1'b1;
		wait_sv();
		chk(sample_data, 16'h0f0f);
		chk(16'(n), 16'h0004);
		@(posedge core_clk);
		want_clk <= 1'b0;
		wr(PIL_OFS_CONTROL, 16'h0002);
		rdchk(PIL_OFS_CONTROL, 16'h0000);
	endtask
	// a write while the clock enable is low must be lost
	task automatic t_freeze();
		@(posedge core_clk);
		clk_en <= 1'b0;
		wr(PIL_OFS_GROUP_MODE, 16'h0001);
		@(posedge core_clk);
		clk_en <= 1'b1;
		rdchk(PIL_OFS_GROUP_MODE, 16'h0000);
	endtask
	// reset while stopped brings the setup back to its reset values
	task automatic t_rst2();
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		rdchk(PIL_OFS_ENABLE_CFG, {12'h000, PIL_ENABLE_CFG_RST});
		rdchk(PIL_OFS_CONTROL, {14'h0, PIL_CONTROL_RST});
	endtask
	// ------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		failures = 0;
		checks_done = 0;
		reset_n = 1'b0;
		clk_en = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		want_probe = 16'h0000;
		want_e1 = 1'b0;
		want_e2 = 1'b0;
		want_clk = 1'b0;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_latch();
		t_demux();
		t_stream();
		t_ext();
		t_freeze();
		t_rst2();
		tally_and_finish();
	end
	// whole run is well under a thousand cycles; this cuts a hang short
	initial begin
		repeat (5000) @(posedge core_clk);
		failures++;
		tally_and_finish();
	end
endmodule
